// ### wtu_defines.vh
// Constants of the watchdog time-out unit.
`ifndef WTU_DEFINES_VH
`define WTU_DEFINES_VH
`define WTU_CTL_ADDR 8'h93
`define WTU_RR_ADDR 8'h94
`define WTU_BIT_EN 7
`define WTU_BIT_NMI 6
`define WTU_BIT_FLAG 5
`define WTU_CLK_HI 4
`define WTU_CLK_LO 3
`define WTU_PER_HI 1
`define WTU_PER_LO 0
`define WTU_CLK_SYS 2'h0
`define WTU_CLK_RTC 2'h1
`define WTU_KEY1 8'hA5
`define WTU_KEY2 8'h5A
`define WTU_PER_27 2'h0
`define WTU_PER_25 2'h1
`define WTU_PER_22 2'h2
`define WTU_PER_18 2'h3
`define WTU_LOG_27 27
`define WTU_LOG_25 25
`define WTU_LOG_22 22
`define WTU_LOG_18 18
`define WTU_CNT_W 27
`define WTU_RST_PULSE 4'h4
`endif

// ### wtu_tick_sync.v
// Two-stage synchroniser and rising-edge detector for the real-time clock source.
module wtu_tick_sync (
   // Clock and reset.
   input wire clk,
   input wire sys_rst,
   // Asynchronous source and synchronised tick.
   input wire src,
   output reg tick_r
);
   reg s1_r;
   reg s2_r;
   reg s3_r;

   always @(posedge clk) begin
      if (sys_rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         s1_r <= src;
         s2_r <= s1_r;
         s3_r <= s2_r;
         tick_r <= s2_r & ~s3_r;
      end
   end
endmodule

// ### wtu_watchdog.v
// Watchdog time-out unit: control and restart registers, counter and time-out response.
//
// How it works
// [R1] Every system reset leaves the watchdog disabled.
// [R2] Writing 1 to bit 7 enables; only reset clears enable.
// [R3] Period field [1:0] picks 2^27, 2^25, 2^22 or 2^18 cycles.
// [R4] Clock select [4:3]: 00 system clock, 01 real-time source, others reserved.
// [R5] Real-time source is whatever the real-time clock control selects.
// [R6] Every time-out sets the cause flag at bit 5.
// [R7] Bit 6 picks response: 0 resets CPU, 1 raises non-maskable interrupt.
// [R8] Time-out reset output changes on rising clock edges only.
// [R9] Cause flag survives watchdog reset; cleared only by other resets.
// [R10] Software trusts the flag only when last reset was not watchdog.
// [R11] Eight-bit readable control; bits 5 and 2 read-only, bit 2 zero.
// [R12] Restart by writing A5h then 5Ah, any delay between them.
// [R13] Completed restart sequence reloads the counter, counting continues.
// [R14] Any value other than 5Ah or A5h after A5h abandons the sequence; A5h again keeps it armed.
`include "wtu_defines.vh"
module wtu_watchdog #(
   parameter CNT_W = `WTU_CNT_W
) (
   // Clock and resets.
   input wire clk,
   input wire sys_rst,
   // High when the system reset in progress was caused by this watchdog.
   input wire wdog_caused_rst,
   // Register port of the processor.
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_r,
   // Real-time clock source, already chosen by the real-time clock control.
   input wire rtc_src,
   // Time-out responses.
   output reg timeout_rst_r,
   output reg timeout_nmi_r
);
   reg enable_r;
   reg nmi_sel_r;
   reg flag_r;
   reg [1:0] clk_sel_r;
   reg [1:0] per_sel_r;
   reg key_armed_r;
   reg [CNT_W-1:0] cnt_r;
   reg [3:0] pulse_r;
   wire rtc_tick;
   wire ctl_wr;
   wire rr_wr;
   wire count_en;
   wire restart;
   wire expire;
   wire [7:0] ctl_val;

   // Returns the terminal count, one less than the selected period.
   // A counter built narrower than the default scales every period by the same power of two.
   function [CNT_W-1:0] wtu_limit;
      input [1:0] sel;
      begin
         case (sel)
            `WTU_PER_27: wtu_limit = {CNT_W{1'b1}} >> (`WTU_CNT_W - `WTU_LOG_27);
            `WTU_PER_25: wtu_limit = {CNT_W{1'b1}} >> (`WTU_CNT_W - `WTU_LOG_25);
            `WTU_PER_22: wtu_limit = {CNT_W{1'b1}} >> (`WTU_CNT_W - `WTU_LOG_22);
            `WTU_PER_18: wtu_limit = {CNT_W{1'b1}} >> (`WTU_CNT_W - `WTU_LOG_18);
            default: wtu_limit = {CNT_W{1'b1}};
         endcase
      end
   endfunction

   // ************************************************
   // Clock source
   // ************************************************
   wtu_tick_sync u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .src(rtc_src),
      .tick_r(rtc_tick)
   );

   // Reserved clock selections do not count.
   assign count_en = enable_r & ((clk_sel_r == `WTU_CLK_SYS) | // R4
      ((clk_sel_r == `WTU_CLK_RTC) & rtc_tick)); // R5

   // ************************************************
   // Register decode
   // ************************************************
   assign ctl_wr = reg_wr & (reg_addr == `WTU_CTL_ADDR);
   assign rr_wr = reg_wr & (reg_addr == `WTU_RR_ADDR);
   assign restart = rr_wr & key_armed_r & (reg_wdata == `WTU_KEY2); // R12
   assign expire = count_en & (cnt_r == wtu_limit(per_sel_r)) & ~restart; // R3
   assign ctl_val = {enable_r, nmi_sel_r, flag_r, clk_sel_r, 1'b0, per_sel_r}; // R11

   always @(posedge clk) begin
      if (sys_rst) begin
         enable_r <= 1'b0; // R1
         nmi_sel_r <= 1'b0;
         clk_sel_r <= 2'h0;
         per_sel_r <= 2'h0;
         reg_rdata_r <= 8'h00;
      end else begin
         if (ctl_wr) begin
            enable_r <= enable_r | reg_wdata[`WTU_BIT_EN]; // R2
            nmi_sel_r <= reg_wdata[`WTU_BIT_NMI];
            clk_sel_r <= reg_wdata[`WTU_CLK_HI:`WTU_CLK_LO];
            per_sel_r <= reg_wdata[`WTU_PER_HI:`WTU_PER_LO];
         end
         if (reg_rd && reg_addr == `WTU_CTL_ADDR) begin
            reg_rdata_r <= ctl_val; // R11
         end else begin
            reg_rdata_r <= 8'h00;
         end
      end
   end

   // ************************************************
   // Cause flag
   // ************************************************
   always @(posedge clk) begin
      if (sys_rst && !wdog_caused_rst) begin
         flag_r <= 1'b0; // R9
      end else if (expire) begin
         flag_r <= 1'b1; // R6
      end
   end

   // ************************************************
   // Restart sequence
   // ************************************************
   always @(posedge clk) begin
      if (sys_rst) begin
         key_armed_r <= 1'b0;
      end else if (rr_wr) begin
         key_armed_r <= (reg_wdata == `WTU_KEY1); // R14
      end
   end

   // ************************************************
   // Counter and response
   // ************************************************
   always @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= {CNT_W{1'b0}};
      end else if (restart || expire) begin
         cnt_r <= {CNT_W{1'b0}}; // R13
      end else if (count_en) begin
         cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // The reset request is stretched so the reset controller sees it.
   always @(posedge clk) begin
      if (sys_rst) begin
         pulse_r <= 4'h0;
         timeout_rst_r <= 1'b0;
         timeout_nmi_r <= 1'b0;
      end else begin
         timeout_nmi_r <= expire & nmi_sel_r; // R7
         if (expire && !nmi_sel_r) begin
            pulse_r <= `WTU_RST_PULSE;
            timeout_rst_r <= 1'b1; // R8
         end else if (pulse_r != 4'h0) begin
            pulse_r <= pulse_r - 4'h1;
            timeout_rst_r <= (pulse_r != 4'h1); // R8
         end else begin
            timeout_rst_r <= 1'b0;
         end
      end
   end
endmodule

// ### wtu_checker.sv
// Port assertions for the watchdog time-out unit.
module wtu_checker #(parameter CNT_W = 27) (
   input wire clk, sys_rst, wdog_caused_rst, reg_rd,
   input wire [7:0] reg_addr, reg_rdata_r,
   input wire timeout_rst_r, timeout_nmi_r
);
   logic flag_r;
   wire rd_c = reg_rd && reg_addr == 8'h93;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   always @(posedge clk)
      if (sys_rst && !wdog_caused_rst) flag_r <= 1'b0;
      else if (timeout_rst_r || timeout_nmi_r) flag_r <= 1'b1;
   boot_idle_a: assert property ($fell(sys_rst) |-> (!timeout_rst_r && !timeout_nmi_r)[*8])
      else $error("early");
   flag_view_a: assert property (rd_c |=> reg_rdata_r[5] == flag_r) else $error("flag");
   rsvd_zero_a: assert property (rd_c |=> !reg_rdata_r[2]) else $error("bit");
   unmapped_a: assert property (reg_rd && !rd_c |=> reg_rdata_r == 8'h00) else $error("rd");
   rst_width_a: assert property ($rose(timeout_rst_r) |-> timeout_rst_r[*4] ##1 !timeout_rst_r)
      else $error("width");
   nmi_gap_a: assert property (timeout_nmi_r |=> (!timeout_nmi_r)[*8]) else $error("nmi");
   rst_gap_a: assert property ($fell(timeout_rst_r) |-> (!timeout_rst_r)[*8]) else $error("rst");
   one_act_a: assert property (!(timeout_rst_r && timeout_nmi_r)) else $error("both");
   cover property ($rose(timeout_rst_r));
   cover property ($rose(timeout_nmi_r));
   cover property (rd_c ##1 reg_rdata_r[5]);
endmodule
bind wtu_watchdog wtu_checker #(.CNT_W(CNT_W)) u_wtu_checker (.*);

// ### wtu_cpu_model.sv
// Processor reset model that obeys the watchdog reset request.
module wtu_cpu_model (
   input wire clk, por, timeout_rst_r,
   output logic sys_rst, wdog_caused_rst
);
   timeunit 1ns / 1ps;
   logic [1:0] hold_r;
   always @(posedge clk)
      if (por) hold_r <= 2'h0;
      else if ($fell(timeout_rst_r)) hold_r <= 2'h2;
      else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
   assign wdog_caused_rst = hold_r != 2'h0 && !por;
   assign sys_rst = por || wdog_caused_rst;
endmodule

// ### tb.sv
// Testbench for the watchdog time-out unit.
module tb;
   timeunit 1ns / 1ps;
   localparam int TB_CNT_W = 20;
   localparam int SHORT_P = 2 ** (TB_CNT_W - 27 + 18);
   logic clk = 0, por = 1, reg_wr = 0, reg_rd = 0, rtc_src = 0;
   logic [1:0] rtc_div = 2'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   wire sys_rst, wdog_caused_rst, timeout_rst_r, timeout_nmi_r;
   wire [7:0] reg_rdata_r;
   int failures = 0, check_count = 0, cyc = 0, t0;
   wtu_watchdog #(.CNT_W(TB_CNT_W)) u_wtu_watchdog (
      .clk(clk),
      .sys_rst(sys_rst),
      .wdog_caused_rst(wdog_caused_rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata_r(reg_rdata_r),
      .rtc_src(rtc_src),
      .timeout_rst_r(timeout_rst_r),
      .timeout_nmi_r(timeout_nmi_r)
   );
   wtu_cpu_model u_wtu_cpu_model (
      .clk(clk),
      .por(por),
      .timeout_rst_r(timeout_rst_r),
      .sys_rst(sys_rst),
      .wdog_caused_rst(wdog_caused_rst)
   );
   initial forever #5 clk = ~clk;
   // Free-running real-time source with a period of four system clocks.
   always @(negedge clk) begin
      rtc_div <= rtc_div + 2'h1;
      rtc_src <= rtc_div[1];
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) failures++;
      if (cyc == 30000) end_sim;
   end
   task chk(input logic [7:0] g, e);
      check_count++;
      if (g !== e) failures++;
      if (g !== e) $display("wrong value at %0t got %h", $time, g);
   endtask
   task acc(input logic w, input logic [7:0] a, d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge clk);
      reg_wr = 0;
      reg_rd = 0;
      if (!w) chk(reg_rdata_r, d);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      por = 0;
      acc(0, 8'h93, 8'h00);
      acc(1, 8'h93, 8'h7F);
      acc(0, 8'h93, 8'h5B);
      acc(0, 8'h94, 8'h00);
      acc(1, 8'h93, 8'hC3);
      acc(1, 8'h93, 8'h43);
      acc(0, 8'h93, 8'hC3);
      $display("test 1 done");
      acc(1, 8'h94, 8'hA5);
      acc(1, 8'h94, 8'h5A);
      t0 = cyc;
      repeat (1000) @(negedge clk);
      acc(1, 8'h94, 8'hA5);
      acc(1, 8'h94, 8'h11);
      acc(1, 8'h94, 8'h5A);
      wait (timeout_nmi_r);
      @(negedge clk);
      check_count++;
      if (cyc - t0 != SHORT_P) begin
         failures++;
         $display("wrong value at %0t period %0d", $time, cyc - t0);
      end
      acc(0, 8'h93, 8'hE3);
      $display("test 2 done");
      acc(1, 8'h93, 8'h83);
      wait (timeout_rst_r);
      repeat (12) @(negedge clk);
      acc(0, 8'h93, 8'h20);
      por = 1;
      @(negedge clk);
      por = 0;
      acc(0, 8'h93, 8'h00);
      $display("test 3 done");
      acc(1, 8'h93, 8'hCB);
      t0 = cyc;
      wait (timeout_nmi_r);
      @(negedge clk);
      check_count++;
      if (cyc - t0 < 4 * SHORT_P - 4 || cyc - t0 > 4 * SHORT_P + 8) begin
         failures++;
         $display("wrong value at %0t rtc period %0d", $time, cyc - t0);
      end
      acc(0, 8'h93, 8'hEB);
      $display("test 4 done");
      end_sim;
   end
endmodule
